// *** hw/pdcf_top.sv ***
// Coefficient registers, fine Clarke real path, extrapolators and low-pass filters of the position DSP.
// Function
// - Fine real Clarke coefficient 1 multiplies filter/rectifier 1 output.
// - Fine real Clarke coefficient 2 applies to filter/rectifier 2 output.
// - Fine real Clarke coefficient 3 applies to filter/rectifier 3 output.
// - Clarke coefficients are signed Q2.14, sixteen bits.
// - Absolute extrapolator gain bits 23:16 come from low byte at 0x22.
// - Absolute extrapolator gain bits 15:0 come from register 0x23.
// - Delay extrapolator gain bits 23:16 come from low byte at 0x26.
// - Delay extrapolator gain bits 15:0 come from register 0x27.
// - Register 0x2A tunes the angle and velocity low-pass filters.
// - Angle filter field 5:4 selects 16, 32, 64, 128; reset 00.
// - Velocity filter field 3:2 selects 16, 32, 64, 128; reset 00.
// - Angle output selects delay-extrapolated, low-pass (10) or absolute (11).
`timescale 1ns/100ps
module pdcf_top
  import pdcf_pkg::*;
#(
  parameter int SW    = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire logic [SW-1:0] smp_fr1,
  input  wire logic [SW-1:0] smp_fr2,
  input  wire logic [SW-1:0] smp_fr3,
  input  wire logic [23:0] abs_angle,
  output logic             angle_valid,
  output logic [23:0]      angle_out,
  output logic [23:0]      velocity_out,
  output logic [31:0]      clarke_real_out
);
  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [15:0] coef1;
    logic [15:0] coef2;
    logic [15:0] coef3;
    logic [7:0]  abs_hi_stage;
    logic [15:0] abs_lo;
    logic [7:0]  dly_hi_stage;
    logic [15:0] dly_lo;
    logic [23:0] abs_gain;
    logic [23:0] dly_gain;
    logic [1:0]  ang_sel;
    logic [1:0]  vel_sel;
    logic [1:0]  out_sel;
    logic [31:0] rdata;
    logic        s1_valid;
    logic        s2_valid;
    logic [31:0] clarke;
    logic [31:0] clarke_s2;
    logic [23:0] prev_ang;
    logic [23:0] vel_raw;
    logic [23:0] dly_ang;
    logic [23:0] abs_ang;
    logic        o_valid;
    logic [23:0] o_angle;
    logic [23:0] o_vel;
    logic [31:0] o_clarke;
    logic [15:0] sample_cnt;
  } pdcf_state_t;

  pdcf_state_t st_ff;
  pdcf_state_t nxt_st;

  logic            f_valid;
  logic            f_ready;
  logic [3*SW-1:0]   f_data;
  logic [23:0]     lp_ang;
  logic [23:0]     lp_vel;
  logic            addr_ok;
  logic [7:0]      a_idx;

  function automatic logic signed [31:0] qmul(input logic [15:0] c, input logic [SW-1:0] x);
    logic signed [47:0] p;
    p = $signed(c) * $signed(x);
    qmul = p[31:0];
  endfunction : qmul

  // Product of a 24-bit velocity and a 24-bit gain scaled back to angle units.
  function automatic logic [23:0] vmul(input logic [23:0] g, input logic [23:0] v);
    logic signed [48:0] p;
    p = $signed({1'b0, g}) * $signed(v);
    vmul = p[39:16];
  endfunction : vmul

  function automatic logic [31:0] rd16(input logic [15:0] v);
    rd16 = {16'h0000, v};
  endfunction : rd16

  pdcf_fifo #(
    .WIDTH (3 * SW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   ({smp_fr3, smp_fr2, smp_fr1}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Sample path never stalls: f_ready is tied high, so the FIFO drains every cycle; outputs are single-cycle pulses.
  assign f_ready = 1'b1;

  pdcf_lowpass #(.W(24)) u_lp_ang (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (st_ff.s1_valid),
    .sel     (st_ff.ang_sel),
    .din     (st_ff.clarke[31:8]),
    .dout    (lp_ang)
  );

  pdcf_lowpass #(.W(24)) u_lp_vel (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (st_ff.s1_valid),
    .sel     (st_ff.vel_sel),
    .din     (st_ff.vel_raw),
    .dout    (lp_vel)
  );

  assign a_idx   = haddr[9:2];
  assign addr_ok = hsel && hready && htrans[1];

  always_comb begin
    logic signed [31:0] sum;
    sum    = '0;
    nxt_st = st_ff;

    // Write data phase: the address was latched in the preceding cycle.
    nxt_st.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      nxt_st.wr_idx = a_idx;
    end
    if (st_ff.wr_pend) begin
      case (st_ff.wr_idx)
        IDX_FINE_REAL_COEF_1:       nxt_st.coef1 = hwdata[15:0];
        IDX_FINE_REAL_COEF_2:       nxt_st.coef2 = hwdata[15:0];
        IDX_FINE_REAL_COEF_3:       nxt_st.coef3 = hwdata[15:0];
        IDX_ABS_EXTRAP_VEL_GAIN_HI: nxt_st.abs_hi_stage = hwdata[7:0];
        IDX_ABS_EXTRAP_VEL_GAIN_LO: begin
          // The high byte is staged; the full gain changes only when the low half lands.
          nxt_st.abs_lo   = hwdata[15:0];
          nxt_st.abs_gain = {st_ff.abs_hi_stage, hwdata[15:0]};
        end
        IDX_DLY_EXTRAP_VEL_GAIN_HI: nxt_st.dly_hi_stage = hwdata[7:0];
        IDX_DLY_EXTRAP_VEL_GAIN_LO: begin
          nxt_st.dly_lo   = hwdata[15:0];
          nxt_st.dly_gain = {st_ff.dly_hi_stage, hwdata[15:0]};
        end
        IDX_LOWPASS_COEF_SELECT: begin
          nxt_st.ang_sel = hwdata[ANG_SEL_LSB +: 2];
          nxt_st.vel_sel = hwdata[VEL_SEL_LSB +: 2];
        end
        IDX_OUTPUT_SELECT: nxt_st.out_sel = hwdata[OUT_SEL_LSB +: 2];
        default: ;
      endcase
    end

    // Reads other than status look at the next values, so a read whose address phase meets a write's data phase is never stale.
    if (addr_ok && !hwrite) begin
      case (a_idx)
        IDX_FINE_REAL_COEF_1:       nxt_st.rdata = rd16(nxt_st.coef1);
        IDX_FINE_REAL_COEF_2:       nxt_st.rdata = rd16(nxt_st.coef2);
        IDX_FINE_REAL_COEF_3:       nxt_st.rdata = rd16(nxt_st.coef3);
        IDX_ABS_EXTRAP_VEL_GAIN_HI: nxt_st.rdata = rd16({8'h00, nxt_st.abs_hi_stage});
        IDX_ABS_EXTRAP_VEL_GAIN_LO: nxt_st.rdata = rd16(nxt_st.abs_lo);
        IDX_DLY_EXTRAP_VEL_GAIN_HI: nxt_st.rdata = rd16({8'h00, nxt_st.dly_hi_stage});
        IDX_DLY_EXTRAP_VEL_GAIN_LO: nxt_st.rdata = rd16(nxt_st.dly_lo);
        IDX_LOWPASS_COEF_SELECT:    nxt_st.rdata = rd16({10'h000, nxt_st.ang_sel, nxt_st.vel_sel, 2'h0});
        IDX_OUTPUT_SELECT:          nxt_st.rdata = rd16({10'h000, nxt_st.out_sel, 4'h0});
        IDX_STATUS:                 nxt_st.rdata = rd16(st_ff.sample_cnt);
        default:                    nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // Stage 1: real part of the transform for filter/rectifier outputs 1 to 3.
    nxt_st.s1_valid = f_valid;
    if (f_valid) begin
      sum = qmul(st_ff.coef1, f_data[0 +: SW])
          + qmul(st_ff.coef2, f_data[SW +: SW])
          + qmul(st_ff.coef3, f_data[2*SW +: SW]);
      nxt_st.clarke     = sum >>> COEF_FRAC;
      // Raw velocity is formed here so that both filters take the same sample on the same edge.
      nxt_st.vel_raw    = nxt_st.clarke[31:8] - st_ff.prev_ang;
      nxt_st.prev_ang   = nxt_st.clarke[31:8];
      nxt_st.sample_cnt = st_ff.sample_cnt + 16'h0001;
    end

    // Stage 2: the filters take the sample; the absolute angle and real part wait for stage 3.
    nxt_st.s2_valid = st_ff.s1_valid;
    if (st_ff.s1_valid) begin
      nxt_st.abs_ang   = abs_angle;
      nxt_st.clarke_s2 = st_ff.clarke;
    end

    // Stage 3: filter outputs now belong to this sample, so extrapolate and select.
    nxt_st.o_valid = st_ff.s2_valid;
    if (st_ff.s2_valid) begin
      nxt_st.dly_ang = lp_ang + vmul(st_ff.dly_gain, lp_vel);
      case (st_ff.out_sel)
        OUT_SEL_LOWPASS:  nxt_st.o_angle = lp_ang;
        OUT_SEL_ABSOLUTE: nxt_st.o_angle = st_ff.abs_ang + vmul(st_ff.abs_gain, lp_vel);
        default:          nxt_st.o_angle = nxt_st.dly_ang;
      endcase
      nxt_st.o_vel    = lp_vel;
      nxt_st.o_clarke = st_ff.clarke_s2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata          = st_ff.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign angle_valid     = st_ff.o_valid;
  assign angle_out       = st_ff.o_angle;
  assign velocity_out    = st_ff.o_vel;
  assign clarke_real_out = st_ff.o_clarke;
endmodule : pdcf_top

// *** hw/pdcf_pkg.sv ***
// Package with register map, field layout and constants of the position DSP coefficient block.
package pdcf_pkg;
  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0] IDX_FINE_REAL_COEF_1       = 8'h1F;
  localparam logic [7:0] IDX_FINE_REAL_COEF_2       = 8'h20;
  localparam logic [7:0] IDX_FINE_REAL_COEF_3       = 8'h21;
  localparam logic [7:0] IDX_ABS_EXTRAP_VEL_GAIN_HI = 8'h22;
  localparam logic [7:0] IDX_ABS_EXTRAP_VEL_GAIN_LO = 8'h23;
  localparam logic [7:0] IDX_DLY_EXTRAP_VEL_GAIN_HI = 8'h26;
  localparam logic [7:0] IDX_DLY_EXTRAP_VEL_GAIN_LO = 8'h27;
  localparam logic [7:0] IDX_LOWPASS_COEF_SELECT    = 8'h2A;
  localparam logic [7:0] IDX_OUTPUT_SELECT          = 8'h2B;
  localparam logic [7:0] IDX_STATUS                 = 8'h30;

  localparam logic [15:0] RST_REG16 = 16'h0000;

  localparam int ANG_SEL_LSB = 4;
  localparam int VEL_SEL_LSB = 2;
  localparam int OUT_SEL_LSB = 4;
  localparam int COEF_FRAC   = 14;

  localparam logic [1:0] OUT_SEL_LOWPASS  = 2'h2;
  localparam logic [1:0] OUT_SEL_ABSOLUTE = 2'h3;

  localparam int FIFO_DEPTH = 16;
  localparam int SAMPLE_W   = 16;
  localparam int FIFO_W     = 3 * SAMPLE_W;
endpackage : pdcf_pkg

// *** hw/pdcf_fifo.sv ***
// Sample FIFO with valid/ready on both sides and registered read data.
`timescale 1ns/100ps
module pdcf_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      cnt_ff;
  logic             oval_ff;
  logic [WIDTH-1:0] odata_ff;
  logic             push;
  logic             pop;
  logic             load;

  // Output register counts as one more storage place, so draining stalls cleanly.
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign load      = (cnt_ff != '0) && (!oval_ff || out_ready);
  assign pop       = load;
  assign out_valid = oval_ff;
  assign out_data  = odata_ff;

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      cnt_ff   <= '0;
      oval_ff  <= 1'b0;
      odata_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff  <= rptr_ff + 1'b1;
        odata_ff <= mem[rptr_ff];
        oval_ff  <= 1'b1;
      end else if (out_ready) begin
        oval_ff <= 1'b0;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pdcf_fifo

// *** hw/pdcf_lowpass.sv ***
// First-order low-pass stage with a selectable power-of-two time constant.
`timescale 1ns/100ps
module pdcf_lowpass #(
  parameter int W = 24
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         en,
  input  wire logic [1:0]   sel,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  // Accumulator keeps 7 extra fraction bits so the slowest setting (128) loses no resolution.
  localparam int AW = W + 7;

  logic signed [AW-1:0] acc_ff;
  logic signed [AW-1:0] err;
  logic signed [AW-1:0] step;

  // Codes 00..11 give coefficients 16, 32, 64, 128.
  always_comb begin
    err  = ($signed({din, 7'h00}) - acc_ff);
    step = err >>> (4 + int'(sel));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= '0;
    end else if (en) begin
      acc_ff <= acc_ff + step;
    end
  end

  assign dout = acc_ff[AW-1:7];
endmodule : pdcf_lowpass

// *** verification/pdcf_top_props.sv ***
// Concurrent checks on the ports of the position DSP coefficient block.
`timescale 1ns/100ps
module pdcf_top_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        smp_valid,
  input wire logic        smp_ready,
  input wire logic        angle_valid,
  input wire logic [23:0] angle_out,
  input wire logic [23:0] velocity_out,
  input wire logic [31:0] clarke_real_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  AST_READY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  AST_UPPER: assert property (rd |=> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_HIBYTE: assert property (rd && (haddr == 32'h88 || haddr == 32'h98) |=> hrdata[31:8] == 24'h0)
    else $error("gain high register wider than a byte");
  AST_UNMAP: assert property (rd && haddr == 32'hFC |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_LAT: assert property (smp_valid && smp_ready |-> ##[1:40] angle_valid)
    else $error("sample taken but no result");
  AST_ANG_HOLD: assert property (!angle_valid |-> $stable(angle_out))
    else $error("angle moved without a result pulse");
  AST_VEL_HOLD: assert property (!angle_valid |-> $stable(velocity_out))
    else $error("velocity moved without a result pulse");
  AST_CLK_HOLD: assert property (!angle_valid |-> $stable(clarke_real_out))
    else $error("real part moved without a result pulse");
  COV_TAKE: cover property (smp_valid && smp_ready);
  COV_RESULT: cover property (angle_valid);
  COV_READ: cover property (rd);
endmodule : pdcf_top_props
bind pdcf_top pdcf_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .smp_valid(smp_valid), .smp_ready(smp_ready), .angle_valid(angle_valid),
  .angle_out(angle_out), .velocity_out(velocity_out), .clarke_real_out(clarke_real_out));

// *** verification/pdcf_smp_src.sv ***
// Model of the demodulated receiver sample path feeding the block.
`timescale 1ns/100ps
module pdcf_smp_src (
  input  wire logic        hclk,
  input  wire logic        smp_ready,
  output logic             smp_valid,
  output logic [15:0]      smp_fr1,
  output logic [15:0]      smp_fr2,
  output logic [15:0]      smp_fr3,
  output logic [23:0]      abs_angle
);
  initial begin
    smp_valid = 1'b0;
    smp_fr1 = 16'h0000;
    smp_fr2 = 16'h0000;
    smp_fr3 = 16'h0000;
    abs_angle = 24'h000000;
  end
  // Called just after an edge; hold keeps valid up so samples go back to back.
  task automatic send(input logic [15:0] f1, f2, f3, input logic [23:0] ang, input logic hold, output logic ok);
    int n;
    smp_valid <= 1'b1;
    smp_fr1 <= f1;
    smp_fr2 <= f2;
    smp_fr3 <= f3;
    abs_angle <= ang;
    n = 0;
    do begin @(posedge hclk); n++; end while (smp_ready !== 1'b1 && n < 50);
    ok = (smp_ready === 1'b1);
    // Released filter/rectifier lines show the inverse so a late capture cannot match by luck.
    if (!hold) begin
      smp_valid <= 1'b0;
      smp_fr1 <= ~f1;
      smp_fr2 <= ~f2;
      smp_fr3 <= ~f3;
    end
  endtask : send
endmodule : pdcf_smp_src

// *** verification/tb_top.sv ***
// Self-checking bench for the position DSP coefficient block.
`timescale 1ns/100ps
module tb_top import pdcf_pkg::*;;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, smp_valid, smp_ready, angle_valid, ok;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, clarke_real_out, q;
  logic [15:0] fr1, fr2, fr3;
  logic [23:0] abs_angle, angle_out, velocity_out;
  logic [7:0]  idx [8] = '{IDX_FINE_REAL_COEF_1, IDX_FINE_REAL_COEF_2, IDX_FINE_REAL_COEF_3,
    IDX_ABS_EXTRAP_VEL_GAIN_HI, IDX_ABS_EXTRAP_VEL_GAIN_LO, IDX_DLY_EXTRAP_VEL_GAIN_HI,
    IDX_DLY_EXTRAP_VEL_GAIN_LO, IDX_LOWPASS_COEF_SELECT};
  int          miscompares = 0;
  int          checked = 0;
  int          pulses = 0;
  pdcf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_fr1(fr1), .smp_fr2(fr2), .smp_fr3(fr3), .abs_angle(abs_angle), .angle_valid(angle_valid),
    .angle_out(angle_out), .velocity_out(velocity_out), .clarke_real_out(clarke_real_out));
  pdcf_smp_src src (.hclk(hclk), .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_fr1(fr1),
    .smp_fr2(fr2), .smp_fr3(fr3), .abs_angle(abs_angle));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) if (angle_valid === 1'b1) pulses <= pulses + 1;
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] ba(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction : ba
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin miscompares++; close_out(); end
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (hreadyout !== 1'b1) begin miscompares++; close_out(); end
  endtask : bus
  task automatic pulse_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : pulse_reset
  task automatic sample(input logic [15:0] f1, f2, f3, input logic [23:0] ang, input logic hold);
    src.send(f1, f2, f3, ang, hold, ok);
    if (!ok) begin miscompares++; close_out(); end
  endtask : sample
  task automatic wait_pulses(input int n);
    for (int t = 0; t < 200 && pulses < n; t++) @(posedge hclk);
    if (pulses < n) begin miscompares++; close_out(); end
  endtask : wait_pulses
  task automatic test_regs();
    logic [31:0] e;
    foreach (idx[i]) begin bus(ba(idx[i]), 1'b0, 0); chk("reset value", q, 0); end
    for (int i = 0; i < 7; i++) begin
      e = 32'hB5C3 + i;
      bus(ba(idx[i]), 1'b1, e);
      bus(ba(idx[i]), 1'b0, 0);
      chk("readback", q, (i == 3 || i == 5) ? (e & 32'hFF) : e);
    end
    for (int k = 0; k < 4; k++) begin
      e = (k << 4) | ((3 - k) << 2);
      bus(ba(IDX_LOWPASS_COEF_SELECT), 1'b1, e);
      bus(ba(IDX_LOWPASS_COEF_SELECT), 1'b0, 0);
      chk("filter select", q, e);
    end
    bus(32'hFC, 1'b1, 32'hFFFF);
    bus(32'hFC, 1'b0, 0);
    chk("unmapped", q, 0);
    for (int i = 0; i < 7; i++) bus(ba(idx[i]), 1'b1, 0);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_clarke();
    int e;
    bus(ba(IDX_FINE_REAL_COEF_1), 1'b1, 32'h4000);
    bus(ba(IDX_FINE_REAL_COEF_2), 1'b1, 32'hC000);
    bus(ba(IDX_FINE_REAL_COEF_3), 1'b1, 32'h2000);
    // Signed Q2.14: 1.0, -1.0 and 0.5 weights.
    e = (16384 * 1000 - 16384 * 300 - 8192 * 400) / 16384;
    sample(16'd1000, 16'd300, -16'sd400, 24'h0, 1'b0);
    wait_pulses(1);
    chk("real part", clarke_real_out, 32'(e));
    $display("test_clarke done");
  endtask : test_clarke
  task automatic test_abs();
    bus(ba(IDX_OUTPUT_SELECT), 1'b1, {26'h0, OUT_SEL_ABSOLUTE, 4'h0});
    sample(16'h0, 16'h0, 16'h0, 24'h5A3C81, 1'b0);
    wait_pulses(2);
    chk("absolute angle", {8'h0, angle_out}, 32'h5A3C81);
    bus(ba(IDX_OUTPUT_SELECT), 1'b1, 0);
    $display("test_abs done");
  endtask : test_abs
  task automatic test_burst();
    for (int i = 0; i < 20; i++) sample(16'h0, 16'h0, 16'd2000, 24'h0, i < 19);
    wait_pulses(22);
    repeat (20) @(posedge hclk);
    chk("result count", pulses, 22);
    chk("last real part", clarke_real_out, 32'd1000);
    $display("test_burst done");
  endtask : test_burst
  // Each pass starts from reset, so a step of 128 moves a filter by 128 over its coefficient.
  task automatic test_filters();
    int c [4] = '{16, 32, 64, 128};
    int a;
    int v;
    int p;
    for (int k = 0; k < 4; k++) begin
      pulse_reset();
      bus(ba(IDX_FINE_REAL_COEF_1), 1'b1, 32'h4000);
      bus(ba(IDX_FINE_REAL_COEF_2), 1'b1, 32'h4000);
      bus(ba(IDX_LOWPASS_COEF_SELECT), 1'b1, 32'((k << 4) | ((3 - k) << 2)));
      // Delay gain of one in this block's 16 fraction bits.
      bus(ba(IDX_DLY_EXTRAP_VEL_GAIN_HI), 1'b1, 32'h01);
      bus(ba(IDX_DLY_EXTRAP_VEL_GAIN_LO), 1'b1, 32'h0);
      // Only the high half of the absolute gain is written, so that gain must still be zero.
      bus(ba(IDX_ABS_EXTRAP_VEL_GAIN_HI), 1'b1, 32'h01);
      bus(ba(IDX_OUTPUT_SELECT), 1'b1, 32'(k << 4));
      p = pulses;
      sample(16'h4000, 16'h4000, 16'h0, 24'h123456, 1'b0);
      wait_pulses(p + 1);
      a = 128 / c[k];
      v = 128 / c[3 - k];
      chk("real part", clarke_real_out, 32'h8000);
      chk("velocity", {8'h0, velocity_out}, 32'(v));
      chk("angle", {8'h0, angle_out}, (k < 2) ? 32'(a + v) : (k == 2) ? 32'(a) : 32'h123456);
      bus(ba(IDX_STATUS), 1'b0, 0);
      chk("sample count", q, 1);
    end
    $display("test_filters done");
  endtask : test_filters
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_clarke();
    test_abs();
    test_burst();
    test_filters();
    close_out();
  end
endmodule : tb_top
